// ===== verilog/usbpc_pkg.sv
// constants shared by the usb power control block and its helpers
package usbpc_pkg;

	// clock rate of core_clk
	localparam int unsigned CLK_HZ = 10_000_000;

	// register indices; byte address is four times the index
	localparam logic [7:0] PWR_IDX = 8'h01;
	localparam logic [7:0] EV_STAT_IDX = 8'h02;
	localparam logic [7:0] EV_MASK_IDX = 8'h03;
	localparam logic [3:0] PWR_ADDR = {PWR_IDX[1:0], 2'b00};
	localparam logic [3:0] EV_STAT_ADDR = {EV_STAT_IDX[1:0], 2'b00};
	localparam logic [3:0] EV_MASK_ADDR = {EV_MASK_IDX[1:0], 2'b00};

	// usb_power_control field positions
	localparam int ISO_BIT = 7;
	localparam int CONN_BIT = 6;
	localparam int RSV_LSB = 4;
	localparam int BRST_BIT = 3;
	localparam int RESUME_BIT = 2;
	localparam int SUSP_BIT = 1;
	localparam int PHYPD_BIT = 0;

	// reset values
	localparam logic [7:0] PWR_RESET = 8'h20;
	localparam logic [1:0] RSV_RESET = 2'h2;
	localparam logic [3:0] EV_MASK_RESET = 4'h0;

	// event status bits
	localparam int EV_BRST = 0;
	localparam int EV_SUSP = 1;
	localparam int EV_ZLP = 2;
	localparam int EV_RSM_LATE = 3;

	// resume signalling window owned by software
	localparam int unsigned RESUME_MIN_MS = 10;
	localparam int unsigned RESUME_MAX_MS = 15;
	localparam int unsigned RESUME_MAX_CYC = CLK_HZ / 1000 * RESUME_MAX_MS;

	// isochronous frame hold states
	typedef enum logic [2:0] {
		ISO_IDLE = 3'b001,
		ISO_WAIT_SOF = 3'b010,
		ISO_RELEASED = 3'b100
	} usbpc_iso_st_t;

endpackage

// ===== verilog/usbpc_iso_if.sv
// carrier between the register core and the isochronous frame hold
`timescale 1ns/100ps
interface usbpc_iso_if;
	logic iso_frame_hold;
	logic tx_packet_ready;
	logic tx_is_iso;
	logic sof_rx;
	logic in_token_rx;
	logic send_pkt;
	logic send_zlp;

	modport core (
		output iso_frame_hold, tx_packet_ready, tx_is_iso, sof_rx, in_token_rx,
		input send_pkt, send_zlp
	);
	modport iso (
		input iso_frame_hold, tx_packet_ready, tx_is_iso, sof_rx, in_token_rx,
		output send_pkt, send_zlp
	);
endinterface

// ===== verilog/usbpc_iso_gate.sv
// isochronous frame hold: releases a queued iso packet only after sof while the hold bit is set
`timescale 1ns/100ps
module usbpc_iso_gate (
	input wire logic core_clk,
	input wire logic rst_sync_b,
	usbpc_iso_if.iso io
);

	typedef struct packed {
		usbpc_pkg::usbpc_iso_st_t st;
		logic pkt;
		logic zlp;
	} usbpc_iso_state_t;

	usbpc_iso_state_t q;
	usbpc_iso_state_t d;
	logic held;

	// hold only applies to iso traffic with the hold bit on
	assign held = io.iso_frame_hold && io.tx_is_iso;

	// next state
	always_comb begin
		d = q;
		d.pkt = 1'b0;
		d.zlp = 1'b0;
		case (q.st)
			usbpc_pkg::ISO_IDLE: begin
				if (held && io.tx_packet_ready) begin
					d.st = usbpc_pkg::ISO_WAIT_SOF;
				end else if (io.in_token_rx && io.tx_packet_ready) begin
					d.pkt = 1'b1;
				end
			end
			usbpc_pkg::ISO_WAIT_SOF: begin
				// hold dropped or endpoint no longer iso: stop holding
				if (!io.tx_packet_ready || !held) begin
					d.st = usbpc_pkg::ISO_IDLE;
					if (io.in_token_rx && io.tx_packet_ready) begin
						d.pkt = 1'b1;
					end
				end else if (io.sof_rx) begin
					d.st = usbpc_pkg::ISO_RELEASED;
				end else if (io.in_token_rx) begin
					d.zlp = 1'b1;
				end
			end
			usbpc_pkg::ISO_RELEASED: begin
				if (!io.tx_packet_ready) begin
					d.st = usbpc_pkg::ISO_IDLE;
				end else if (io.in_token_rx) begin
					d.pkt = 1'b1;
					d.st = usbpc_pkg::ISO_IDLE;
				end
			end
			default: begin
				d.st = usbpc_pkg::ISO_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			q <= '{st: usbpc_pkg::ISO_IDLE, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign io.send_pkt = q.pkt;
	assign io.send_zlp = q.zlp;

endmodule

// ===== verilog/usbpc_power_ctl.sv
// usb device power control register with avalon slave and interrupts
`timescale 1ns/100ps
module usbpc_power_ctl #(
	parameter int unsigned RESUME_MAX_CYC = usbpc_pkg::RESUME_MAX_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic usb_reset_seen,
	input wire logic usb_suspend_seen,
	input wire logic sof_rx,
	input wire logic in_token_rx,
	input wire logic tx_packet_ready,
	input wire logic tx_is_iso,
	output logic send_pkt,
	output logic send_zlp,
	output logic line_oe_b,
	output logic resume_drive,
	output logic phy_power_down,
	output logic usb_irq
);

	localparam int CNT_W = $clog2(RESUME_MAX_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(RESUME_MAX_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// register selects
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_PWR = 2'h1;
	localparam logic [1:0] SEL_STAT = 2'h2;
	localparam logic [1:0] SEL_MASK = 2'h3;

	typedef struct packed {
		logic iso_hold;
		logic soft_conn;
		logic bus_rst;
		logic resume;
		logic resume_drv;
		logic suspend;
		logic phy_pd;
		logic [3:0] ev_stat;
		logic [3:0] ev_mask;
		logic irq;
		logic wait_b;
		logic [7:0] rdata;
		logic [CNT_W-1:0] rsm_cnt;
		logic line_oe_b;
	} usbpc_core_st_t;

	localparam usbpc_core_st_t ST_RST = '{
		iso_hold: usbpc_pkg::PWR_RESET[usbpc_pkg::ISO_BIT],
		soft_conn: usbpc_pkg::PWR_RESET[usbpc_pkg::CONN_BIT],
		bus_rst: usbpc_pkg::PWR_RESET[usbpc_pkg::BRST_BIT],
		resume: usbpc_pkg::PWR_RESET[usbpc_pkg::RESUME_BIT],
		resume_drv: 1'b0,
		suspend: usbpc_pkg::PWR_RESET[usbpc_pkg::SUSP_BIT],
		phy_pd: usbpc_pkg::PWR_RESET[usbpc_pkg::PHYPD_BIT],
		ev_stat: 4'h0,
		ev_mask: usbpc_pkg::EV_MASK_RESET,
		irq: 1'b0,
		wait_b: 1'b1,
		rdata: 8'h00,
		rsm_cnt: '0,
		line_oe_b: 1'b1
	};

	logic [1:0] rsync_q;
	logic rst_sync_b;
	usbpc_core_st_t q;
	usbpc_core_st_t d;
	logic [1:0] sel;
	logic commit_wr;
	logic commit_rd;
	logic [7:0] wd;
	logic [3:0] ev;

	usbpc_iso_if iso_io ();

	// decode a byte address into a register select
	function automatic logic [1:0] reg_sel(input logic [3:0] addr);
		logic [1:0] s;
		s = SEL_NONE;
		if (addr == usbpc_pkg::PWR_ADDR) begin
			s = SEL_PWR;
		end else if (addr == usbpc_pkg::EV_STAT_ADDR) begin
			s = SEL_STAT;
		end else if (addr == usbpc_pkg::EV_MASK_ADDR) begin
			s = SEL_MASK;
		end
		return s;
	endfunction

	// read view of the power register
	function automatic logic [7:0] pwr_view(input usbpc_core_st_t s);
		logic [7:0] v;
		v = 8'h00;
		v[usbpc_pkg::ISO_BIT] = s.iso_hold;
		v[usbpc_pkg::CONN_BIT] = s.soft_conn;
		v[usbpc_pkg::RSV_LSB +: 2] = usbpc_pkg::RSV_RESET;
		v[usbpc_pkg::BRST_BIT] = s.bus_rst;
		v[usbpc_pkg::RESUME_BIT] = s.resume;
		v[usbpc_pkg::SUSP_BIT] = s.suspend;
		v[usbpc_pkg::PHYPD_BIT] = s.phy_pd;
		return v;
	endfunction

	// reset release through two flops; assert is immediate
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsync_q <= 2'b00;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_sync_b = rsync_q[1];

	// feed the frame hold helper
	assign iso_io.iso_frame_hold = q.iso_hold;
	assign iso_io.tx_packet_ready = tx_packet_ready;
	assign iso_io.tx_is_iso = tx_is_iso;
	assign iso_io.sof_rx = sof_rx;
	assign iso_io.in_token_rx = in_token_rx;

	usbpc_iso_gate u_iso (
		.core_clk(core_clk),
		.rst_sync_b(rst_sync_b),
		.io(iso_io)
	);

	// bus access decode; one wait state, commit when wait drops
	assign sel = reg_sel(avs_address);
	assign commit_wr = avs_write && !q.wait_b;
	assign commit_rd = avs_read && !q.wait_b;
	assign wd = avs_writedata[7:0];

	// events feeding the sticky status
	always_comb begin
		ev = 4'h0;
		ev[usbpc_pkg::EV_BRST] = usb_reset_seen && !q.bus_rst;
		ev[usbpc_pkg::EV_SUSP] = usb_suspend_seen && !q.suspend;
		ev[usbpc_pkg::EV_ZLP] = iso_io.send_zlp;
		ev[usbpc_pkg::EV_RSM_LATE] = q.resume_drv &&
			(q.rsm_cnt == CNT_MAX - CNT_ONE);
	end

	// next state of the whole core
	always_comb begin
		d = q;

		// answer each request once, then hold wait high again
		d.wait_b = 1'b1;
		if ((avs_read || avs_write) && q.wait_b) begin
			d.wait_b = 1'b0;
			case (sel)
				SEL_PWR: d.rdata = pwr_view(q);
				SEL_STAT: d.rdata = {4'h0, q.ev_stat};
				SEL_MASK: d.rdata = {4'h0, q.ev_mask};
				default: d.rdata = 8'h00;
			endcase
		end

		d.bus_rst = usb_reset_seen;

		// power register writes, lane 0 only
		if (commit_wr && avs_byteenable[0] && sel == SEL_PWR) begin
			d.iso_hold = wd[usbpc_pkg::ISO_BIT];
			d.soft_conn = wd[usbpc_pkg::CONN_BIT];
			d.resume = wd[usbpc_pkg::RESUME_BIT];
			if (wd[usbpc_pkg::RESUME_BIT] && q.suspend) begin
				d.resume_drv = 1'b1;
			end
			if (!wd[usbpc_pkg::RESUME_BIT]) begin
				d.resume_drv = 1'b0;
			end
			if (wd[usbpc_pkg::PHYPD_BIT]) begin
				d.phy_pd = 1'b1;
			end
		end

		// clear suspend on event read or resume
		if (commit_rd && sel == SEL_STAT) begin
			d.suspend = 1'b0;
		end
		if (commit_wr && avs_byteenable[0] && sel == SEL_PWR &&
			wd[usbpc_pkg::RESUME_BIT]) begin
			d.suspend = 1'b0;
		end
		if (usb_suspend_seen) begin
			d.suspend = 1'b1;
		end

		// status is write one to clear, events win over the clear
		if (commit_wr && avs_byteenable[0] && sel == SEL_STAT) begin
			d.ev_stat = q.ev_stat & ~wd[3:0];
		end
		d.ev_stat = d.ev_stat | ev;
		if (commit_wr && avs_byteenable[0] && sel == SEL_MASK) begin
			d.ev_mask = wd[3:0];
		end

		// resume length watchdog, saturates at the limit
		if (q.resume_drv) begin
			if (q.rsm_cnt != CNT_MAX) begin
				d.rsm_cnt = q.rsm_cnt + CNT_ONE;
			end
		end else begin
			d.rsm_cnt = '0;
		end

		// outputs taken from next values so they line up with state
		d.irq = |(d.ev_stat & d.ev_mask);
		// lines float unless soft connect set
		d.line_oe_b = !d.soft_conn;
	end

	// single state register
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	// ports straight from flops; upper bytes are always zero
	assign avs_readdata = {24'h00_0000, q.rdata};
	assign avs_waitrequest = q.wait_b;
	assign line_oe_b = q.line_oe_b;
	assign resume_drive = q.resume_drv;
	assign phy_power_down = q.phy_pd;
	assign usb_irq = q.irq;
	assign send_pkt = iso_io.send_pkt;
	assign send_zlp = iso_io.send_zlp;

endmodule

// ===== bench/usbpc_asserts.sv
// port checker for the usb power control block
`timescale 1ns/100ps
module usbpc_asserts (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic in_token_rx,
	input wire logic tx_packet_ready,
	input wire logic tx_is_iso,
	input wire logic send_pkt,
	input wire logic send_zlp,
	input wire logic line_oe_b,
	input wire logic resume_drive,
	input wire logic phy_power_down,
	input wire logic usb_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// bus request accepted, and a power register read accepted
	sequence s_taken;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_pwr_read;
		s_taken ##0 (avs_read && avs_address == 4'h4);
	endsequence
	a_wait_pulse: assert property (
		s_taken |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not one low cycle");
	a_rsv_read: assert property (
		s_pwr_read |=> avs_readdata[31:8] == 24'h00_0000
			&& avs_readdata[5:4] == 2'h2)
		else $error("reserved field wrong");
	a_conn_line: assert property (
		s_pwr_read |=> avs_readdata[6] == !line_oe_b)
		else $error("line enable differs from connect bit");
	a_pkt_cause: assert property (
		send_pkt |-> $past(in_token_rx) && $past(tx_packet_ready))
		else $error("packet sent without in token");
	a_zlp_cause: assert property (
		send_zlp |-> $past(in_token_rx) && $past(tx_is_iso) && !send_pkt)
		else $error("empty packet without iso in token");
	a_plain_direct: assert property (
		in_token_rx && tx_packet_ready && !tx_is_iso |=> send_pkt)
		else $error("non iso packet held");
	a_phy_sticky: assert property (
		phy_power_down |=> phy_power_down)
		else $error("phy power down cleared");
	a_resume_cause: assert property (
		$rose(resume_drive) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("resume rose without write");
	a_irq_masked: assert property (
		avs_write && !avs_waitrequest && avs_address == 4'hC
			&& avs_byteenable[0]
			&& avs_writedata[3:0] == 4'h0 |=> !usb_irq)
		else $error("irq high with mask clear");
endmodule

bind usbpc_power_ctl usbpc_asserts chk_i (.core_clk, .rst_b, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest,
	.in_token_rx, .tx_packet_ready, .tx_is_iso, .send_pkt, .send_zlp,
	.line_oe_b, .resume_drive, .phy_power_down, .usb_irq);

// ===== bench/usbpc_host_model.sv
// usb host stand-in: tokens and bus line states
`timescale 1ns/100ps
module usbpc_host_model (
	input wire logic core_clk,
	output logic sof_rx,
	output logic in_token_rx,
	output logic usb_reset_seen,
	output logic usb_suspend_seen
);
	// quiet bus at start
	initial begin
		sof_rx = 1'b0;
		in_token_rx = 1'b0;
		usb_reset_seen = 1'b0;
		usb_suspend_seen = 1'b0;
	end
	// one-cycle event: 0 sof, 1 in token, 2 suspend
	task pulse(input int k);
		@(posedge core_clk);
		sof_rx <= (k == 0);
		in_token_rx <= (k == 1);
		usb_suspend_seen <= (k == 2);
		@(posedge core_clk);
		sof_rx <= 1'b0;
		in_token_rx <= 1'b0;
		usb_suspend_seen <= 1'b0;
	endtask
	// bus reset is a level the host holds
	task bus_reset(input logic lvl);
		@(posedge core_clk);
		usb_reset_seen <= lvl;
	endtask
endmodule

// ===== bench/usb_device_power_control_bench.sv
// self-checking bench for the usb power control register
`timescale 1ns/100ps
module usb_device_power_control_bench;
	logic core_clk, rst_b, avs_read, avs_write, tx_packet_ready, tx_is_iso;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic avs_waitrequest, sof_rx, in_token_rx, usb_reset_seen;
	logic usb_suspend_seen, send_pkt, send_zlp, line_oe_b;
	logic resume_drive, phy_power_down, usb_irq;
	int n_fail, cmp_count;
	// packet counters have one driver, the counting process
	int n_pkt = 0;
	int n_zlp = 0;

	// short resume limit keeps the late case brief
	usbpc_power_ctl #(.RESUME_MAX_CYC(50)) uut (.core_clk, .rst_b,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest,
		.usb_reset_seen, .usb_suspend_seen, .sof_rx, .in_token_rx,
		.tx_packet_ready, .tx_is_iso, .send_pkt, .send_zlp, .line_oe_b,
		.resume_drive, .phy_power_down, .usb_irq);
	usbpc_host_model host (.core_clk, .sof_rx, .in_token_rx,
		.usb_reset_seen, .usb_suspend_seen);

	// 100 ns clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// count packet pulses, each stands one cycle
	always @(posedge core_clk) begin
		n_pkt <= n_pkt + int'(send_pkt === 1'b1);
		n_zlp <= n_zlp + int'(send_zlp === 1'b1);
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one access; request held until waitrequest is seen low
	task bus(input logic r, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		avs_read <= r;
		avs_write <= !r;
		avs_address <= a;
		// upper lanes carry junk the block must ignore
		avs_writedata <= {~d, d, ~d, d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			finish_test;
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		bus(1'b1, a, 8'h00);
		chk(q[7:0], e);
	endtask
	task tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	initial begin
		{rst_b, avs_read, avs_write, tx_packet_ready, tx_is_iso} = 5'h00;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h1;
		{n_fail, cmp_count} = 64'h0;
		tick(16);
		rst_b <= 1'b1;
		tick(3);
		chk({7'h00, line_oe_b}, 8'h01);
		rd(4'h4, 8'h20);
		rd(4'h0, 8'h00);
		wr(4'h0, 8'hFF);
		// read-only bits ignore the write, phy bit is set-only
		wr(4'h4, 8'hDB);
		rd(4'h4, 8'hE1);
		chk({6'h00, line_oe_b, phy_power_down}, 8'h01);
		wr(4'h4, 8'h80);
		rd(4'h4, 8'hA1);
		chk({7'h00, line_oe_b}, 8'h01);
		// bus reset level, its event and the interrupt
		host.bus_reset(1'b1);
		tick(3);
		rd(4'h4, 8'hA9);
		host.bus_reset(1'b0);
		tick(3);
		rd(4'h4, 8'hA1);
		// lane 0 disabled: power write must be dropped
		avs_byteenable <= 4'hE;
		wr(4'h4, 8'h40);
		avs_byteenable <= 4'h1;
		rd(4'h4, 8'hA1);
		chk({7'h00, line_oe_b}, 8'h01);
		wr(4'hC, 8'h0F);
		tick(2);
		chk({7'h00, usb_irq}, 8'h01);
		wr(4'h8, 8'h01);
		tick(2);
		chk({7'h00, usb_irq}, 8'h00);
		// suspend flag, read clear, then resume in time
		host.pulse(2);
		tick(2);
		rd(4'h4, 8'hA3);
		rd(4'h8, 8'h02);
		rd(4'h4, 8'hA1);
		wr(4'h4, 8'h85);
		tick(2);
		chk({7'h00, resume_drive}, 8'h00);
		host.pulse(2);
		wr(4'h4, 8'h85);
		tick(2);
		chk({7'h00, resume_drive}, 8'h01);
		rd(4'h4, 8'hA5);
		tick(28);
		wr(4'h4, 8'h81);
		tick(2);
		chk({7'h00, resume_drive}, 8'h00);
		rd(4'h8, 8'h02);
		// resume left on too long flags the late event
		host.pulse(2);
		wr(4'h4, 8'h85);
		tick(60);
		rd(4'h8, 8'h0A);
		wr(4'h4, 8'h81);
		wr(4'h8, 8'h0F);
		// iso hold: empty packet before sof, real one after
		tx_is_iso <= 1'b1;
		tx_packet_ready <= 1'b1;
		tick(2);
		host.pulse(1);
		tick(2);
		chk(n_zlp[7:0], 8'h01);
		chk(n_pkt[7:0], 8'h00);
		host.pulse(0);
		host.pulse(1);
		tick(2);
		chk(n_pkt[7:0], 8'h01);
		tx_is_iso <= 1'b0;
		host.pulse(1);
		tick(2);
		chk(n_pkt[7:0], 8'h02);
		// hold off: iso packet goes on first in token
		wr(4'h4, 8'h01);
		tx_is_iso <= 1'b1;
		host.pulse(1);
		tick(2);
		chk(n_pkt[7:0], 8'h03);
		chk(n_zlp[7:0], 8'h01);
		rd(4'h8, 8'h04);
		chk({7'h00, usb_irq}, 8'h01);
		wr(4'hC, 8'h00);
		tick(2);
		chk({7'h00, usb_irq}, 8'h00);
		finish_test;
	end
endmodule
